/* core/efcd_core.sv */
// Function
// [RULE1] Frame opens with seven preamble bytes of 55h.
// [RULE2] One delimiter byte 5Dh follows the preamble.
// [RULE3] Destination then source address, six bytes each.
// [RULE4] Two-byte length/type field follows the addresses.
// [RULE5] Drop received frames matching no own, multicast, broadcast or promiscuous path.
// [RULE6] Data field padded to at least 46 bytes.
// [RULE7] Pad precedes the check sequence and is covered by it.
// [RULE8] Data field limited to max_rx_frame_length minus 18.
// [RULE9] Four-byte CRC generated on transmit, checked on receive.
// [RULE10] Check sequence kept in or left out of memory by configuration.
// [RULE11] Contention handling only in half duplex.
// [RULE12] Wait for idle medium plus inter-packet gap before sending; code keeps the gap only after carrier was seen in TX_DEFER.
// [RULE13] Collision during transmit replaces frame with 48-bit jam.
// [RULE14] After jam, random backoff scaled by collision count, then retry.
// [RULE15] Frame sent without collision is complete, never resent.
// [RULE16] Descriptor: next, buffer pointer, offset/length, flags/packet length.
// [RULE17] Descriptors describe transmit packets and empty receive buffers.
// [RULE18] Chained descriptors sent as one contiguous frame.
// [RULE19] Frames shorter than 64 or above max length are invalid.
// [RULE20] PHY holds collision_in while a collision lasts.
// [RULE21] PHY holds carrier_sense_in while medium is busy.
// [RULE22] Aborted outgoing frame carries inverted CRC.
// [RULE23] Carrier and collision pass two flip-flops before use.
// [RULE24] Bytes go out low nibble first with valid held over the frame.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module efcd_core #(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Nibble link to the PHY
  input  wire logic        TX_CLK_IN,
  input  wire logic        RX_CLK_IN,
  input  wire logic [3:0]  RXD_IN,
  input  wire logic        RX_DV_IN,
  input  wire logic        CARRIER_SENSE_IN,
  input  wire logic        COLLISION_IN,
  output logic      [3:0]  TXD_OUT,
  output logic             TX_NIBBLE_VALID_OUT
);

  if (AW < 2 || AW > 9) begin : g_chk
    $error("AW must lie in 2..9");
  end

  // Local buffer and descriptor memory
  logic [31:0] mem_q [1 << AW];

  efcd_pkg::efcd_pins_s pins_in, sync1_q, sync2_q;
  logic        prev_tx_q, prev_rx_q, tx_tick, rx_tick;
  logic [31:0] ctrl_q, tx_head_q, rx_head_q, mac_lo_q, mac_hi_q;
  logic [15:0] maxlen_q;
  logic        go_q, acc, apb_ram_we;
  logic        fdx, col_hit, crs;
  efcd_pkg::efcd_tx_e tx_st_q;
  efcd_pkg::efcd_desc_s cur_q, tx_desc, rx_desc;
  logic [31:0] ptr_q, first_q, crc_q, baddr, fcs_word;
  logic [15:0] cnt_q, pos_q, fcnt_q;
  logic [9:0]  bo_q, bo_mask;
  logic [3:0]  bo_k;
  logic [4:0]  att_q;
  logic        nib_hi_q, start_q, bad_q, seen_q, excess_q;
  logic [7:0]  tx_byte, tx_done_q;
  logic        tx_send;
  logic [15:0] lfsr_q;
  efcd_pkg::efcd_rx_e rx_st_q;
  logic [3:0]  rx_lo_q;
  logic        rx_hi_q, own_q, bc_q, mc_q;
  logic [15:0] rx_cnt_q;
  logic [31:0] rx_crc_q, rx_addr, rx_wr_data;
  logic [7:0]  rx_byte, rx_good_q, rx_drop_q;
  logic        rx_ev, rx_fin, rx_ok, rx_wr_en;
  logic [AW-1:0] rx_wr_idx;
  logic [47:0] own_mac;

  // [RULE23] two-stage sync
  // Every pin from the PHY is resampled twice before use
  assign pins_in = '{TX_CLK_IN, RX_CLK_IN, RX_DV_IN, CARRIER_SENSE_IN,
                     COLLISION_IN, RXD_IN};
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      prev_tx_q <= 1'b0;
      prev_rx_q <= 1'b0;
    end else if (CE_IN) begin
      sync1_q   <= pins_in;
      sync2_q   <= sync1_q;
      prev_tx_q <= sync2_q.tx_clk;
      prev_rx_q <= sync2_q.rx_clk;
    end
  end

  // Link clock edges; the PHY samples on its rising edge, so drive just after
  assign tx_tick = CE_IN && sync2_q.tx_clk && !prev_tx_q;
  assign rx_tick = CE_IN && sync2_q.rx_clk && !prev_rx_q;
  assign fdx     = ctrl_q[efcd_pkg::CTRL_FDX];
  // [RULE11] half duplex only
  assign col_hit = !fdx && sync2_q.col;
  assign crs     = !fdx && sync2_q.crs;

  // [RULE16] descriptor layout
  // Descriptor pointers are byte addresses into the local memory
  function automatic efcd_pkg::efcd_desc_s rd_desc(input logic [31:0] p);
    logic [AW-1:0] i;
    i = p[AW+1:2];
    return {mem_q[i], mem_q[AW'(i + 1)], mem_q[AW'(i + 2)], mem_q[AW'(i + 3)]};
  endfunction : rd_desc

  // Process, not assign: must wake on memory writes read inside the function
  always_comb begin
    tx_desc = rd_desc(ptr_q);
    rx_desc = rd_desc(rx_head_q);
  end

  // APB access completes one cycle after the access phase opens;
  // held off while the receiver owns the memory port
  assign acc        = PSEL_IN && PENABLE_IN && !PREADY_OUT && !rx_wr_en && CE_IN;
  assign apb_ram_we = acc && PWRITE_IN && PADDR_IN[efcd_pkg::RAM_SEL_BIT];

  // Register file and APB answer
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q      <= '0;
      tx_head_q   <= '0;
      rx_head_q   <= '0;
      mac_lo_q    <= '0;
      mac_hi_q    <= '0;
      maxlen_q    <= efcd_pkg::MAXLEN_RST;
      go_q        <= 1'b0;
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= '0;
      PSLVERR_OUT <= 1'b0;
    end else if (CE_IN) begin
      go_q        <= 1'b0;
      PREADY_OUT  <= acc;
      PSLVERR_OUT <= 1'b0;
      if (acc) begin
        PRDATA_OUT <= '0;
        if (PADDR_IN[efcd_pkg::RAM_SEL_BIT]) begin
          if (!PWRITE_IN) PRDATA_OUT <= mem_q[PADDR_IN[AW+1:2]];
        end else if (PADDR_IN == efcd_pkg::REG_CTRL) begin
          if (PWRITE_IN) begin
            ctrl_q <= PWDATA_IN & efcd_pkg::CTRL_RW;
            go_q   <= PWDATA_IN[efcd_pkg::CTRL_GO];
          end else PRDATA_OUT <= ctrl_q;
        end else if (PADDR_IN == efcd_pkg::REG_TX_HEAD) begin
          if (PWRITE_IN) tx_head_q <= PWDATA_IN;
          else PRDATA_OUT <= tx_head_q;
        end else if (PADDR_IN == efcd_pkg::REG_RX_HEAD) begin
          if (PWRITE_IN) rx_head_q <= PWDATA_IN;
          else PRDATA_OUT <= rx_head_q;
        end else if (PADDR_IN == efcd_pkg::REG_MAC_LO) begin
          if (PWRITE_IN) mac_lo_q <= PWDATA_IN;
          else PRDATA_OUT <= mac_lo_q;
        end else if (PADDR_IN == efcd_pkg::REG_MAC_HI) begin
          if (PWRITE_IN) mac_hi_q <= {16'h0, PWDATA_IN[15:0]};
          else PRDATA_OUT <= mac_hi_q;
        end else if (PADDR_IN == efcd_pkg::REG_MAXLEN) begin
          if (PWRITE_IN) maxlen_q <= PWDATA_IN[15:0];
          else PRDATA_OUT <= {16'h0, maxlen_q};
        end else if (PADDR_IN == efcd_pkg::REG_STATUS) begin
          if (!PWRITE_IN) PRDATA_OUT <= {rx_drop_q, rx_good_q, tx_done_q, excess_q,
                                         att_q, 1'b0, tx_st_q != efcd_pkg::TX_IDLE};
        end else begin
          PSLVERR_OUT <= 1'b1;
        end
      end
    end
  end

  // [RULE17] shared memory
  // Receive writes win the single port; APB waits a cycle instead
  always_ff @(posedge REF_CLK_IN) begin
    if (rx_wr_en) mem_q[rx_wr_idx] <= rx_wr_data;
    else if (apb_ram_we) mem_q[PADDR_IN[AW+1:2]] <= PWDATA_IN;
  end

  // Free-running LFSR for backoff draws
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) lfsr_q <= 16'hace1;
    else if (CE_IN) lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // [RULE14] range grows with collisions
  assign bo_k    = (att_q + 5'h1 >= {1'b0, efcd_pkg::BACKOFF_CAP}) ? efcd_pkg::BACKOFF_CAP
                                                                   : 4'(att_q + 5'h1);
  assign bo_mask = 10'h3ff >> (efcd_pkg::BACKOFF_CAP - bo_k);

  // [RULE22] bad frames keep the raw register
  assign baddr    = cur_q.buf_ptr + {16'h0, cur_q.buf_off} + {16'h0, pos_q};
  assign fcs_word = bad_q ? crc_q : ~crc_q;
  assign tx_send  = tx_st_q inside {efcd_pkg::TX_PRE, efcd_pkg::TX_DATA,
                                    efcd_pkg::TX_PAD, efcd_pkg::TX_FCS};

  // [RULE1] [RULE2] byte source
  always_comb begin
    tx_byte = 8'h00;
    case (tx_st_q)
      efcd_pkg::TX_PRE:  tx_byte = (cnt_q < efcd_pkg::PRE_BYTES) ? efcd_pkg::PRE_BYTE
                                                                 : efcd_pkg::SFD_BYTE;
      efcd_pkg::TX_DATA: tx_byte = mem_q[baddr[AW+1:2]][{baddr[1:0], 3'b000} +: 8];
      efcd_pkg::TX_FCS:  tx_byte = fcs_word[{cnt_q[1:0], 3'b000} +: 8];
      default:           tx_byte = 8'h00;
    endcase
  end

  // Transmit sequencer; outputs change only on link clock edges
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_st_q <= efcd_pkg::TX_IDLE;
      cur_q <= '0; ptr_q <= '0; first_q <= '0; crc_q <= efcd_pkg::CRC_INIT;
      cnt_q <= '0; pos_q <= '0; fcnt_q <= '0; bo_q <= '0; att_q <= '0;
      nib_hi_q <= 1'b0; start_q <= 1'b0; bad_q <= 1'b0; seen_q <= 1'b0;
      excess_q <= 1'b0; tx_done_q <= '0;
      TXD_OUT <= '0; TX_NIBBLE_VALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (tx_tick) TX_NIBBLE_VALID_OUT <= 1'b0;
      case (tx_st_q)
        efcd_pkg::TX_IDLE: if (go_q) begin
          ptr_q <= tx_head_q; first_q <= tx_head_q; att_q <= '0;
          excess_q <= 1'b0; start_q <= 1'b1; tx_st_q <= efcd_pkg::TX_FETCH;
        end
        efcd_pkg::TX_FETCH: begin
          cur_q <= tx_desc; pos_q <= '0; cnt_q <= '0; seen_q <= 1'b0;
          tx_st_q <= start_q ? efcd_pkg::TX_DEFER : efcd_pkg::TX_DATA;
        end
        // [RULE12] defer on carrier
        efcd_pkg::TX_DEFER: if (tx_tick) begin
          if (crs) begin
            seen_q <= 1'b1; cnt_q <= '0;
          end else if (!seen_q || cnt_q == efcd_pkg::IPG_NIBS - 16'h1) begin
            cnt_q <= '0; nib_hi_q <= 1'b0; bad_q <= 1'b0; start_q <= 1'b0;
            tx_st_q <= efcd_pkg::TX_PRE;
          end else cnt_q <= cnt_q + 16'h1;
        end
        efcd_pkg::TX_JAM: if (tx_tick) begin
          TXD_OUT <= efcd_pkg::JAM_NIB; TX_NIBBLE_VALID_OUT <= 1'b1;
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q == efcd_pkg::JAM_NIBS - 16'h1) begin
            att_q <= att_q + 5'h1; cnt_q <= '0;
            // [RULE14] draw the backoff
            bo_q <= lfsr_q[9:0] & bo_mask;
            if (att_q + 5'h1 == efcd_pkg::MAX_ATTEMPTS) begin
              excess_q <= 1'b1; tx_st_q <= efcd_pkg::TX_END;
            end else tx_st_q <= efcd_pkg::TX_BACKOFF;
          end
        end
        // [RULE14] wait whole slots
        efcd_pkg::TX_BACKOFF: if (tx_tick) begin
          if (bo_q == '0) begin
            ptr_q <= first_q; start_q <= 1'b1; tx_st_q <= efcd_pkg::TX_FETCH;
          end else if (cnt_q == efcd_pkg::SLOT_NIBS - 16'h1) begin
            cnt_q <= '0; bo_q <= bo_q - 10'h1;
          end else cnt_q <= cnt_q + 16'h1;
        end
        // [RULE15] done without retry
        efcd_pkg::TX_END: if (tx_tick) begin
          tx_done_q <= tx_done_q + 8'h1; tx_st_q <= efcd_pkg::TX_IDLE;
        end
        default: if (tx_tick) begin
          if (col_hit) begin
            // [RULE13] jam on collision
            TXD_OUT <= efcd_pkg::JAM_NIB; TX_NIBBLE_VALID_OUT <= 1'b1;
            cnt_q <= 16'h1; tx_st_q <= efcd_pkg::TX_JAM;
          end else begin
            // [RULE24] low nibble first
            TXD_OUT <= nib_hi_q ? tx_byte[7:4] : tx_byte[3:0];
            TX_NIBBLE_VALID_OUT <= 1'b1;
            nib_hi_q <= !nib_hi_q;
            if (nib_hi_q) begin
              case (tx_st_q)
                efcd_pkg::TX_PRE: begin
                  cnt_q <= cnt_q + 16'h1;
                  if (cnt_q == efcd_pkg::PRE_BYTES) begin
                    fcnt_q <= '0; crc_q <= efcd_pkg::CRC_INIT; tx_st_q <= efcd_pkg::TX_DATA;
                  end
                end
                // [RULE3] [RULE4] header from buffer
                efcd_pkg::TX_DATA: begin
                  crc_q  <= efcd_pkg::crc_byte(crc_q, tx_byte);
                  fcnt_q <= fcnt_q + 16'h1;
                  pos_q  <= pos_q + 16'h1;
                  cnt_q  <= '0;
                  // [RULE8] [RULE22] overlong or aborted
                  if (ctrl_q[efcd_pkg::CTRL_ABORT] ||
                      fcnt_q + 16'h1 >= maxlen_q - efcd_pkg::FCS_BYTES) begin
                    bad_q <= 1'b1; tx_st_q <= efcd_pkg::TX_FCS;
                  end else if (pos_q + 16'h1 == cur_q.buf_len) begin
                    // [RULE18] follow the chain
                    if (cur_q.next != '0) begin
                      ptr_q <= cur_q.next; tx_st_q <= efcd_pkg::TX_FETCH;
                    // [RULE10] check sequence from memory
                    end else if (ctrl_q[efcd_pkg::CTRL_CRCMEM]) tx_st_q <= efcd_pkg::TX_END;
                    // [RULE6] pad short payload
                    else if (fcnt_q + 16'h1 < efcd_pkg::MIN_BODY) tx_st_q <= efcd_pkg::TX_PAD;
                    else tx_st_q <= efcd_pkg::TX_FCS;
                  end
                end
                // [RULE7] pad inside CRC
                efcd_pkg::TX_PAD: begin
                  crc_q  <= efcd_pkg::crc_byte(crc_q, tx_byte);
                  fcnt_q <= fcnt_q + 16'h1;
                  if (fcnt_q + 16'h1 == efcd_pkg::MIN_BODY) tx_st_q <= efcd_pkg::TX_FCS;
                end
                // [RULE9] append four CRC bytes
                default: begin
                  cnt_q <= cnt_q + 16'h1;
                  if (cnt_q == efcd_pkg::FCS_BYTES - 16'h1) tx_st_q <= efcd_pkg::TX_END;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Receive byte assembly and memory writes
  assign rx_byte = {sync2_q.rxd, rx_lo_q};
  assign rx_ev   = rx_tick && sync2_q.rx_dv && rx_hi_q && rx_st_q == efcd_pkg::RX_BODY;
  assign rx_fin  = rx_tick && !sync2_q.rx_dv && rx_st_q == efcd_pkg::RX_BODY;
  assign rx_addr = rx_desc.buf_ptr + {16'h0, rx_desc.buf_off} + {16'h0, rx_cnt_q};
  // [RULE5] [RULE9] [RULE19] accept test
  assign rx_ok = rx_cnt_q >= efcd_pkg::MIN_FRAME && rx_cnt_q <= maxlen_q &&
                 rx_crc_q == efcd_pkg::CRC_RESIDUE &&
                 (ctrl_q[efcd_pkg::CTRL_PROMIS] || own_q ||
                  (bc_q && ctrl_q[efcd_pkg::CTRL_BCAST]) ||
                  (mc_q && !bc_q && ctrl_q[efcd_pkg::CTRL_MCAST]));

  // Bytes land read-modify-write; the descriptor length is patched at the end
  always_comb begin
    rx_wr_en   = 1'b0;
    rx_wr_idx  = rx_addr[AW+1:2];
    rx_wr_data = mem_q[rx_addr[AW+1:2]];
    if (rx_ev && rx_cnt_q < rx_desc.buf_len) begin
      rx_wr_en = 1'b1;
      rx_wr_data[{rx_addr[1:0], 3'b000} +: 8] = rx_byte;
    end else if (rx_fin && rx_ok) begin
      rx_wr_en   = 1'b1;
      rx_wr_idx  = AW'(rx_head_q[AW+1:2] + 3);
      // [RULE10] strip check sequence
      rx_wr_data = {16'h0, ctrl_q[efcd_pkg::CTRL_CRCMEM] ? rx_cnt_q
                                                         : rx_cnt_q - efcd_pkg::FCS_BYTES};
    end
  end

  // Own address, byte 0 first on the wire
  assign own_mac = {mac_hi_q[15:0], mac_lo_q};

  // Receive sequencer
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_st_q <= efcd_pkg::RX_HUNT; rx_lo_q <= '0; rx_hi_q <= 1'b0;
      rx_cnt_q <= '0; rx_crc_q <= efcd_pkg::CRC_INIT;
      own_q <= 1'b0; bc_q <= 1'b0; mc_q <= 1'b0; rx_good_q <= '0; rx_drop_q <= '0;
    end else if (rx_tick) begin
      if (!sync2_q.rx_dv || !ctrl_q[efcd_pkg::CTRL_RX_EN]) begin
        rx_hi_q <= 1'b0;
        rx_st_q <= efcd_pkg::RX_HUNT;
        // [RULE5] [RULE19] drop or keep
        if (rx_fin && rx_ok) rx_good_q <= rx_good_q + 8'h1;
        else if (rx_fin) rx_drop_q <= rx_drop_q + 8'h1;
      end else if (!rx_hi_q) begin
        rx_lo_q <= sync2_q.rxd; rx_hi_q <= 1'b1;
      end else begin
        rx_hi_q <= 1'b0;
        if (rx_st_q == efcd_pkg::RX_HUNT) begin
          if (rx_byte == efcd_pkg::SFD_BYTE) begin
            rx_st_q <= efcd_pkg::RX_BODY; rx_cnt_q <= '0; rx_crc_q <= efcd_pkg::CRC_INIT;
            own_q <= 1'b1; bc_q <= 1'b1; mc_q <= 1'b0;
          end
        end else begin
          rx_cnt_q <= rx_cnt_q + 16'h1;
          rx_crc_q <= efcd_pkg::crc_byte(rx_crc_q, rx_byte);
          // [RULE5] destination compare
          if (rx_cnt_q < efcd_pkg::ADDR_BYTES) begin
            if (rx_byte != own_mac[{rx_cnt_q[2:0], 3'b000} +: 8])
              own_q <= 1'b0;
            if (rx_byte != 8'hff) bc_q <= 1'b0;
            if (rx_cnt_q == '0) mc_q <= rx_byte[0];
          end
        end
      end
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_preamble_nibble: assert property ( // [RULE1]
    (tx_st_q == efcd_pkg::TX_PRE && tx_tick && !col_hit && cnt_q < efcd_pkg::PRE_BYTES)
    |=> TXD_OUT == efcd_pkg::PRE_BYTE[3:0] && TX_NIBBLE_VALID_OUT)
    else $error("preamble nibble wrong");
  chk_sfd_byte: assert property ( // [RULE2]
    (tx_st_q == efcd_pkg::TX_PRE && tx_tick && !col_hit && cnt_q == efcd_pkg::PRE_BYTES
     && !nib_hi_q) |=> TXD_OUT == efcd_pkg::SFD_BYTE[3:0])
    else $error("delimiter low nibble wrong");
  chk_jam_on_col: assert property ( // [RULE13]
    (tx_send && tx_tick && col_hit) |=> tx_st_q == efcd_pkg::TX_JAM &&
    TXD_OUT == efcd_pkg::JAM_NIB)
    else $error("collision did not start jam");
  chk_fdx_no_jam: assert property ( // [RULE11]
    (tx_send && tx_tick && fdx) |=> tx_st_q != efcd_pkg::TX_JAM)
    else $error("jam in full duplex");
  chk_pad_min_len: assert property ( // [RULE6]
    $rose(tx_st_q == efcd_pkg::TX_FCS) && !bad_q |-> fcnt_q >= efcd_pkg::MIN_BODY)
    else $error("check sequence before minimum length");
  chk_defer_busy: assert property ( // [RULE12]
    (tx_st_q == efcd_pkg::TX_DEFER && tx_tick && crs) |=> tx_st_q == efcd_pkg::TX_DEFER)
    else $error("started on busy medium");
  chk_valid_data: assert property ( // [RULE24]
    (tx_st_q == efcd_pkg::TX_DATA && tx_tick && !col_hit) |=> TX_NIBBLE_VALID_OUT)
    else $error("valid dropped inside frame");
  chk_rx_short: assert property ( // [RULE19]
    (rx_fin && rx_cnt_q < efcd_pkg::MIN_FRAME) |=> $stable(rx_good_q))
    else $error("short frame accepted");
  chk_done_once: assert property ( // [RULE15]
    (tx_st_q == efcd_pkg::TX_END && tx_tick) |=> tx_st_q == efcd_pkg::TX_IDLE ##1
    tx_st_q == efcd_pkg::TX_IDLE)
    else $error("completed frame resent");

  cov_clean_frame: cover property (tx_st_q == efcd_pkg::TX_END && tx_tick && att_q == '0);
  cov_backoff: cover property (tx_st_q == efcd_pkg::TX_BACKOFF && bo_q != '0);
  cov_rx_good: cover property (rx_fin && rx_ok);

endmodule : efcd_core

/* core/efcd_pkg.sv */
package efcd_pkg;

  // Frame layout
  localparam logic [7:0]  PRE_BYTE    = 8'h55;
  localparam logic [7:0]  SFD_BYTE    = 8'h5d;
  localparam logic [15:0] PRE_BYTES   = 16'h0007;
  localparam logic [15:0] ADDR_BYTES  = 16'h0006;
  localparam logic [15:0] MIN_BODY    = 16'h003c;
  localparam logic [15:0] MIN_FRAME   = 16'h0040;
  localparam logic [15:0] FCS_BYTES   = 16'h0004;
  localparam logic [15:0] MAXLEN_RST  = 16'h05ee;

  // Medium access timing, in nibble times
  localparam logic [15:0] JAM_NIBS     = 16'h000c;
  localparam logic [15:0] IPG_NIBS     = 16'h0018;
  localparam logic [15:0] SLOT_NIBS    = 16'h0080;
  localparam logic [4:0]  MAX_ATTEMPTS = 5'h10;
  localparam logic [3:0]  BACKOFF_CAP  = 4'ha;
  localparam logic [3:0]  JAM_NIB      = 4'h5;

  // Check sequence
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_TX_HEAD = 12'h004;
  localparam logic [11:0] REG_RX_HEAD = 12'h008;
  localparam logic [11:0] REG_STATUS  = 12'h00c;
  localparam logic [11:0] REG_MAC_LO  = 12'h010;
  localparam logic [11:0] REG_MAC_HI  = 12'h014;
  localparam logic [11:0] REG_MAXLEN  = 12'h018;
  localparam int          RAM_SEL_BIT = 11;

  // Control bits
  localparam int          CTRL_GO     = 0;
  localparam int          CTRL_FDX    = 1;
  localparam int          CTRL_CRCMEM = 2;
  localparam int          CTRL_PROMIS = 3;
  localparam int          CTRL_MCAST  = 4;
  localparam int          CTRL_BCAST  = 5;
  localparam int          CTRL_RX_EN  = 6;
  localparam int          CTRL_ABORT  = 7;
  localparam logic [31:0] CTRL_RW     = 32'h000000fe;

  // Four-word buffer descriptor
  typedef struct packed {
    logic [31:0] next;
    logic [31:0] buf_ptr;
    logic [15:0] buf_off;
    logic [15:0] buf_len;
    logic [15:0] flags;
    logic [15:0] pkt_len;
  } efcd_desc_s;

  // Pins crossing into the reference clock
  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    logic       rx_dv;
    logic       crs;
    logic       col;
    logic [3:0] rxd;
  } efcd_pins_s;

  typedef enum logic [9:0] {
    TX_IDLE    = 10'h001,
    TX_FETCH   = 10'h002,
    TX_DEFER   = 10'h004,
    TX_PRE     = 10'h008,
    TX_DATA    = 10'h010,
    TX_PAD     = 10'h020,
    TX_FCS     = 10'h040,
    TX_JAM     = 10'h080,
    TX_BACKOFF = 10'h100,
    TX_END     = 10'h200
  } efcd_tx_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'h1,
    RX_BODY = 2'h2
  } efcd_rx_e;

  // Reflected byte-wise CRC update
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ b[i]) ? CRC_POLY : 32'h0);
    end
    return r;
  endfunction : crc_byte

endpackage : efcd_pkg

/* test/efcd_core_tb.sv */
`timescale 1ns/1ps
module efcd_core_tb;
  logic clk, rst_n, psel, pen, pwr, busy, perr, prdy;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, r;
  logic [3:0] txd, rxd;
  logic txv, txc, rxc, rdv, crs, col, e;
  logic [7:0] f[0:59], x[0:71];
  logic [31:0] c;
  int fails, n_checks, seed, cyc, k, n;
  efcd_core efcd_core_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .TX_CLK_IN(txc), .RX_CLK_IN(rxc),
    .RXD_IN(rxd), .RX_DV_IN(rdv), .CARRIER_SENSE_IN(crs), .COLLISION_IN(col),
    .TXD_OUT(txd), .TX_NIBBLE_VALID_OUT(txv));
  efcd_phy_model efcd_phy_model_inst (.tx_clk_out(txc), .rx_clk_out(rxc), .crs_out(crs),
    .col_out(col), .rxd_out(rxd), .rx_dv_out(rdv), .txd_in(txd), .txv_in(txv), .busy_in(busy));
  // Clock and a hang guard of 20000 cycles
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for the slave's ready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    {psel, pen, pwr, busy, paddr, pwd, fails, n_checks, cyc} = '0;
    seed = 92842;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h018, 32'h0);
    chk(r, 32'h000005ee);
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    // Random 24-byte packet, zero pad to 60, reflected CRC over all 60
    for (k = 0; k < 60; k++) f[k] = (k < 24) ? 8'($random(seed)) : 8'h00;
    c = 32'hffffffff;
    for (k = 0; k < 480; k++) c = (c >> 1) ^ ((c[0] ^ f[k/8][k%8]) ? 32'hedb88320 : 32'h0);
    for (k = 0; k < 72; k++) x[k] = (k < 7) ? 8'h55 : (k == 7) ? 8'h5d : (k < 68) ? f[k-8]
      : 8'(~c >> (8 * (k - 68)));
    apb(1'b1, 12'h800, 32'h0);
    apb(1'b1, 12'h804, 32'h10);
    apb(1'b1, 12'h808, 32'h18);
    apb(1'b1, 12'h80c, 32'h0);
    for (k = 0; k < 6; k++) apb(1'b1, 12'(12'h810 + 4 * k),
      {f[4*k+3], f[4*k+2], f[4*k+1], f[4*k]});
    busy <= 1'b1;
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    repeat (60) @(posedge clk);
    chk({31'h0, txv}, 32'h0);
    busy <= 1'b0;
    for (k = 0; k < 4000 && efcd_phy_model_inst.q.size() < 72; k++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk(efcd_phy_model_inst.q.size(), 32'd72);
    for (k = 0; k < 72; k++)
      chk({24'h0, efcd_phy_model_inst.q[k]}, {24'h0, x[k]});
    apb(1'b0, 12'h00c, 32'h0);
    chk({24'h0, r[15:8]}, 32'h1);
    $display("test frame done");
    // Full duplex: busy medium and collision ignored, frame goes out at once
    busy <= 1'b1;
    apb(1'b1, 12'h000, 32'h3);
    for (k = 0; k < 4000 && efcd_phy_model_inst.q.size() < 144; k++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk(efcd_phy_model_inst.q.size(), 32'd144);
    for (k = 0; k < 72; k++)
      chk({24'h0, efcd_phy_model_inst.q[72+k]}, {24'h0, x[k]});
    $display("test duplex done");
    // Half duplex, foreign traffic sixteen bytes in: jam, back off, resend whole
    busy <= 1'b0;
    apb(1'b1, 12'h000, 32'h1);
    for (k = 0; k < 4000 && efcd_phy_model_inst.q.size() < 160; k++) @(posedge clk);
    busy <= 1'b1;
    repeat (400) @(posedge clk);
    busy <= 1'b0;
    repeat (3000) @(posedge clk);
    apb(1'b0, 12'h00c, 32'h0);
    chk({24'h0, r[15:8]}, 32'h3);
    chk({27'h0, r[6:2]}, 32'h1);
    n = efcd_phy_model_inst.q.size() - 72;
    chk({31'h0, n > 160}, 32'h1);
    for (k = 0; k < 72; k++)
      chk({24'h0, efcd_phy_model_inst.q[n+k]}, {24'h0, x[k]});
    $display("test collision done");
    end_of_test();
  end
endmodule : efcd_core_tb

/* test/efcd_phy_model.sv */
`timescale 1ns/1ps
module efcd_phy_model (
  // Clocks and line status
  output logic            tx_clk_out,
  output logic            rx_clk_out,
  output logic            crs_out,
  output logic            col_out,
  // Receive lines, released here
  output logic [3:0]      rxd_out,
  output logic            rx_dv_out,
  // Transmit lines and bench control
  input  wire logic [3:0] txd_in,
  input  wire logic       txv_in,
  input  wire logic       busy_in
);
  logic [7:0] q[$];
  logic       hi_q;
  logic [3:0] lo_q;
  // Link clocks run free at 200 ns, out of phase with each other
  initial begin
    tx_clk_out = 1'b0;
    forever #100 tx_clk_out = ~tx_clk_out;
  end
  initial begin
    rx_clk_out = 1'b0;
    #37;
    forever #100 rx_clk_out = ~rx_clk_out;
  end
  initial begin
    hi_q = 1'b0;
    lo_q = 4'h0;
    rx_dv_out = 1'b0;
    rxd_out = 4'h0;
  end
  // Foreign traffic during own transmit is a collision
  assign col_out = txv_in & busy_in;
  // Busy for own or foreign traffic
  assign crs_out = txv_in | busy_in;
  // Released data toggles so a stale value never looks valid
  always @(posedge rx_clk_out) rxd_out <= ~rxd_out;
  always @(posedge tx_clk_out) begin
    if (txv_in) begin
      if (hi_q) q.push_back({txd_in, lo_q});
      lo_q <= txd_in;
      hi_q <= ~hi_q;
    end else hi_q <= 1'b0;
  end
endmodule : efcd_phy_model
